// file: src/decoder_pkg.sv
package decoder_pkg;

   // ***********************************
   // ALU function codes
   // ***********************************
   localparam logic [3:0] ALU_PASS_NZ = 4'h0;
   localparam logic [3:0] ALU_CLEAR   = 4'h1;
   localparam logic [3:0] ALU_SUB     = 4'h2;
   localparam logic [3:0] ALU_DEC     = 4'h3;
   localparam logic [3:0] ALU_OR      = 4'h4;
   localparam logic [3:0] ALU_AND     = 4'h5;
   localparam logic [3:0] ALU_XOR     = 4'h6;
   localparam logic [3:0] ALU_ADD     = 4'h7;
   localparam logic [3:0] ALU_PASS_Z  = 4'h8;
   localparam logic [3:0] ALU_NOT     = 4'h9;
   localparam logic [3:0] ALU_INC     = 4'hA;
   localparam logic [3:0] ALU_BIT_CLR = 4'hB;
   localparam logic [3:0] ALU_ROT_R   = 4'hC;
   localparam logic [3:0] ALU_ROT_L   = 4'hD;
   localparam logic [3:0] ALU_SWAP    = 4'hE;
   localparam logic [3:0] ALU_BIT_SET = 4'hF;

   // Standard group, indexed by word bits 9..6
   localparam logic [3:0] STD_ALU [16] = '{
      ALU_PASS_NZ, ALU_CLEAR, ALU_SUB, ALU_DEC, ALU_OR, ALU_AND, ALU_XOR, ALU_ADD,
      ALU_PASS_Z, ALU_NOT, ALU_INC, ALU_DEC, ALU_ROT_R, ALU_ROT_L, ALU_SWAP, ALU_INC};
   // Immediate group, indexed by word bits 9..8
   localparam logic [3:0] IMM_ALU [4] = '{ALU_PASS_NZ, ALU_OR, ALU_AND, ALU_XOR};

   // ***********************************
   // Op-codes and fields
   // ***********************************
   localparam logic [11:0] OP_NOP        = 12'h000;
   localparam logic [11:0] OP_TIMER_OPT  = 12'h002;
   localparam logic [11:0] OP_SLEEP      = 12'h003;
   localparam logic [11:0] OP_WDT_RESET  = 12'h004;
   localparam logic [4:0]  PC_REG        = 5'h02;
   localparam logic [4:0]  INDIRECT_REG  = 5'h00;

   // ***********************************
   // Register map
   // ***********************************
   localparam logic [11:0] CTRL_OFS      = 12'h000;
   localparam logic [11:0] STAT_OFS      = 12'h004;
   localparam logic [11:0] COUNT_OFS     = 12'h008;
   localparam int          CTRL_PRST_BIT = 0;

   typedef enum logic [2:0] {
      ST_EXEC  = 3'b001,
      ST_EXTRA = 3'b010,
      ST_SLEEP = 3'b100
   } state_t;

   typedef struct packed {
      logic [3:0] alu;
      logic       acc_we;
      logic       reg_we;
      logic [4:0] reg_addr;
      logic [2:0] bit_num;
      logic [7:0] literal;
      logic [8:0] target;
      logic       jump;
      logic       call;
      logic       ret;
      logic [2:0] port;
      logic       tmr;
      logic       sleep;
      logic       wdt;
      logic       two;
      logic       skip_zero;
      logic       skip_bclr;
      logic       skip_bset;
   } dec_t;

endpackage : decoder_pkg

// file: src/op_decoder_unit.sv
// Functional notes
// - Implicit codes are matched on all twelve bits.
// - Implicit codes drive only their own enables; no-op drives none.
// - Port direction move uses low three bits to pick the port.
// - Standard group: register field, destination bit, sixteen ALU ops, one cycle, two when writing the program counter register.
// - Bit 5 picks destination: one register, zero accumulator.
// - Accumulator destination raises accumulator load, else register write.
// - Accumulator-to-register move always has destination bit set.
// - Skip instructions take one cycle, two when skipping; tests pass through.
// - Branches take two cycles with pass-through ALU function.
// - Jump target is the low nine word bits.
// - Call target is low eight bits; subroutines in lower half.
// - Bitwise ops act on registers only, result back to source.
// - Immediate ops combine eight-bit literal with accumulator in one cycle.
// - Power-down stops fetches; clocks keep running for the watchdog.
// - Power-down holds until master reset from watchdog, pin or software.
// - Power-down drives the sleep indication output.
// - Power-down also restarts the watchdog with a single pulse.
// - Two-cycle register writes carry identical data in both cycles.
// - Next word is prefetched, memory gets a full cycle.
// - Four-bit ALU function code follows the fixed encoding.
// - Next-instruction strobe late by one cycle for two-cycle ops.
// - Register field zero routes index low bits onto the address.
// - Master reset loads a no-op into the instruction register.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module op_decoder_unit #(
   parameter int unsigned PADDR_W = 12
) (
   // Clock and reset
   input  wire logic               ref_clk,
   input  wire logic               rstn,
   // Reset sources
   input  wire logic               watchdog_reset,
   input  wire logic               ext_reset_pin,
   // Instruction memory and datapath status
   input  wire logic [11:0]        fetch_word,
   input  wire logic [4:0]         index_low,
   input  wire logic               zero_result,
   input  wire logic               bit_test_result,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [PADDR_W-1:0] paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic [31:0]             prdata,
   output logic                    pslverr,
   // Instruction register and ALU control
   output logic [11:0]             instruction_word,
   output logic                    next_instruction_strobe,
   output logic [3:0]              alu_function_code,
   output logic                    accumulator_load_en,
   output logic                    register_write_en,
   output logic [4:0]              register_address,
   output logic [2:0]              bit_number,
   output logic [7:0]              literal_value,
   // Program counter control
   output logic [8:0]              pc_target,
   output logic                    pc_jump_en,
   output logic                    pc_call_en,
   output logic                    pc_return_en,
   // Implicit controls
   output logic                    port0_dir_load_en,
   output logic                    port1_dir_load_en,
   output logic                    port2_dir_load_en,
   output logic                    timer_option_load_en,
   output logic                    watchdog_restart,
   output logic                    power_down_ctl,
   output logic                    sleep_out
);

   // ***********************************
   // Decode
   // ***********************************
   function automatic decoder_pkg::dec_t decode(input logic [11:0] w, input logic [4:0] idx);
      decoder_pkg::dec_t d;
      d = '0;
      d.reg_addr = (w[4:0] == decoder_pkg::INDIRECT_REG) ? idx : w[4:0];
      d.bit_num  = w[7:5];
      d.literal  = w[7:0];
      d.alu      = decoder_pkg::ALU_PASS_NZ;
      unique case (w[11:10])
         2'b00:
         begin
            if (w[9:5] == 5'h00)
            begin
               // Unlisted codes here fall through with nothing set
               if (w == decoder_pkg::OP_TIMER_OPT)
                  d.tmr = 1'b1;
               else if (w == decoder_pkg::OP_SLEEP)
               begin
                  d.sleep = 1'b1;
                  d.wdt   = 1'b1;
               end
               else if (w == decoder_pkg::OP_WDT_RESET)
                  d.wdt = 1'b1;
               else if (w[4:0] == 5'h05)
                  d.port = 3'b001;
               else if (w[4:0] == 5'h06)
                  d.port = 3'b010;
               else if (w[4:0] == 5'h07)
                  d.port = 3'b100;
            end
            else
            begin
               // Move from accumulator only exists with bit 5 set
               d.alu       = decoder_pkg::STD_ALU[w[9:6]];
               d.acc_we    = ~w[5];
               d.reg_we    = w[5];
               d.two       = w[5] && (d.reg_addr == decoder_pkg::PC_REG);
               d.skip_zero = (w[9:6] == 4'hB) || (w[9:6] == 4'hF);
            end
         end
         2'b01:
         begin
            unique case (w[9:8])
               2'b00:
               begin
                  d.alu    = decoder_pkg::ALU_BIT_CLR;
                  d.reg_we = 1'b1;
               end
               2'b01:
               begin
                  d.alu    = decoder_pkg::ALU_BIT_SET;
                  d.reg_we = 1'b1;
               end
               2'b10:
                  d.skip_bclr = 1'b1;
               2'b11:
                  d.skip_bset = 1'b1;
            endcase
            d.two = d.reg_we && (d.reg_addr == decoder_pkg::PC_REG);
         end
         2'b10:
         begin
            d.two = 1'b1;
            if (w[9])
            begin
               d.jump   = 1'b1;
               d.target = w[8:0];
            end
            else if (w[8])
            begin
               d.call   = 1'b1;
               d.target = {1'b0, w[7:0]};
            end
            else
            begin
               d.ret    = 1'b1;
               d.acc_we = 1'b1;
            end
         end
         2'b11:
         begin
            d.alu    = decoder_pkg::IMM_ALU[w[9:8]];
            d.acc_we = 1'b1;
         end
      endcase
      return d;
   endfunction : decode

   function automatic logic hit(input logic [PADDR_W-1:0] a, input logic [11:0] ofs);
      return a == PADDR_W'(ofs);
   endfunction : hit

   decoder_pkg::state_t st_q;
   decoder_pkg::dec_t   cur_q;
   decoder_pkg::dec_t   nxt;
   logic [1:0]          ext_sync_q;
   logic                prst_q;
   logic                master_reset;
   logic                skip_now;
   logic [11:0]         load_word;
   logic [31:0]         count_q;
   logic                wr_fire;
   logic                rd_take;

   // ***********************************
   // Master reset
   // ***********************************
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         ext_sync_q <= 2'b00;
      else
         ext_sync_q <= {ext_sync_q[0], ext_reset_pin};
   end

   assign master_reset = watchdog_reset | ext_sync_q[1] | prst_q;

   // ***********************************
   // Sequencing
   // ***********************************
   assign skip_now = (cur_q.skip_zero & zero_result) |
                     (cur_q.skip_bclr & ~bit_test_result) |
                     (cur_q.skip_bset & bit_test_result);
   // Skipped word is replaced so its slot becomes the second cycle
   assign load_word = skip_now ? decoder_pkg::OP_NOP : fetch_word;
   assign nxt = decode(load_word, index_low);

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_q                    <= decoder_pkg::ST_EXEC;
         cur_q                   <= '0;
         instruction_word        <= 12'h000;
         next_instruction_strobe <= 1'b1;
      end
      else if (master_reset)
      begin
         st_q                    <= decoder_pkg::ST_EXEC;
         cur_q                   <= '0;
         instruction_word        <= decoder_pkg::OP_NOP;
         next_instruction_strobe <= 1'b1;
      end
      else
      begin
         unique case (st_q)
            decoder_pkg::ST_EXEC, decoder_pkg::ST_EXTRA:
            begin
               if (next_instruction_strobe)
               begin
                  cur_q            <= nxt;
                  instruction_word <= load_word;
                  if (nxt.sleep)
                  begin
                     st_q                    <= decoder_pkg::ST_SLEEP;
                     next_instruction_strobe <= 1'b0;
                  end
                  else
                  begin
                     st_q                    <= decoder_pkg::ST_EXEC;
                     next_instruction_strobe <= ~nxt.two;
                  end
               end
               else
               begin
                  // Decode held, both register writes see the same data
                  st_q                    <= decoder_pkg::ST_EXTRA;
                  next_instruction_strobe <= 1'b1;
               end
            end
            decoder_pkg::ST_SLEEP:
               next_instruction_strobe <= 1'b0;
            default:
            begin
               st_q                    <= decoder_pkg::ST_EXEC;
               cur_q                   <= '0;
               next_instruction_strobe <= 1'b1;
            end
         endcase
      end
   end

   assign alu_function_code    = cur_q.alu;
   assign accumulator_load_en  = cur_q.acc_we;
   assign register_write_en    = cur_q.reg_we;
   assign register_address     = cur_q.reg_addr;
   assign bit_number           = cur_q.bit_num;
   assign literal_value        = cur_q.literal;
   assign pc_target            = cur_q.target;
   assign pc_jump_en           = cur_q.jump;
   assign pc_call_en           = cur_q.call;
   assign pc_return_en         = cur_q.ret;
   assign port0_dir_load_en    = cur_q.port[0];
   assign port1_dir_load_en    = cur_q.port[1];
   assign port2_dir_load_en    = cur_q.port[2];
   assign timer_option_load_en = cur_q.tmr;

   // ***********************************
   // Power-down and watchdog restart
   // ***********************************
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         power_down_ctl <= 1'b0;
         sleep_out      <= 1'b0;
      end
      else if (master_reset)
      begin
         power_down_ctl <= 1'b0;
         sleep_out      <= 1'b0;
      end
      else if (next_instruction_strobe && st_q != decoder_pkg::ST_SLEEP && nxt.sleep)
      begin
         power_down_ctl <= 1'b1;
         sleep_out      <= 1'b1;
      end
   end

   // Pulse from the load, not the held flag, so it fires once
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         watchdog_restart <= 1'b0;
      else
         watchdog_restart <= ~master_reset & next_instruction_strobe & nxt.wdt;
   end

   // ***********************************
   // APB registers
   // ***********************************
   assign wr_fire = psel & penable & pready & pwrite;
   assign rd_take = psel & penable & ~pready;

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= rd_take;
         pslverr <= rd_take & ~(hit(paddr, decoder_pkg::CTRL_OFS) | hit(paddr, decoder_pkg::STAT_OFS) |
                                hit(paddr, decoder_pkg::COUNT_OFS));
         if (rd_take && !pwrite && hit(paddr, decoder_pkg::STAT_OFS))
            prdata <= {13'h0000, st_q, 3'h0, power_down_ctl, instruction_word};
         else if (rd_take && !pwrite && hit(paddr, decoder_pkg::COUNT_OFS))
            prdata <= count_q;
         else
            prdata <= 32'h0000_0000;
      end
   end

   // Software reset: write one, self clearing
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         prst_q <= 1'b0;
      else
         prst_q <= wr_fire & hit(paddr, decoder_pkg::CTRL_OFS) & pwdata[decoder_pkg::CTRL_PRST_BIT];
   end

   // Loads since reset; a write clears it
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         count_q <= 32'h0000_0000;
      else if (wr_fire && hit(paddr, decoder_pkg::COUNT_OFS))
         count_q <= 32'h0000_0000;
      else if (next_instruction_strobe && !master_reset && st_q != decoder_pkg::ST_SLEEP)
         count_q <= count_q + 32'h0000_0001;
   end

   // ***********************************
   // Assertions
   // ***********************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   sequence strobe_late_s;
      !next_instruction_strobe ##1 next_instruction_strobe;
   endsequence

   nop_quiet_a: assert property ((instruction_word == 12'h000 || instruction_word == 12'h001) |->
      !(accumulator_load_en | register_write_en | pc_jump_en | pc_call_en | timer_option_load_en |
        port0_dir_load_en | port1_dir_load_en | port2_dir_load_en) && next_instruction_strobe)
      else $error("no-op asserted a control");
   port_dir_a: assert property (instruction_word == 12'h006 |->
      port1_dir_load_en && !port0_dir_load_en && !port2_dir_load_en)
      else $error("port direction enable wrong");
   acc_dest_a: assert property ((instruction_word[11:10] == 2'b00 && instruction_word[9:6] != 4'h0 &&
      !instruction_word[5]) |-> accumulator_load_en && !register_write_en)
      else $error("accumulator destination wrong");
   move_dest_a: assert property (instruction_word[11:5] == 7'h01 |->
      register_write_en && !accumulator_load_en && alu_function_code == 4'h0)
      else $error("accumulator move destination wrong");
   skip_nop_a: assert property ((next_instruction_strobe && skip_now && !master_reset) |=>
      instruction_word == 12'h000 && !register_write_en)
      else $error("skipped word not flushed");
   branch_two_a: assert property (disable iff (!rstn || master_reset)
      (next_instruction_strobe && !skip_now && fetch_word[11:10] == 2'b10) |=>
      alu_function_code == 4'h0 ##0 strobe_late_s)
      else $error("branch not two cycles");
   jump_tgt_a: assert property (instruction_word[11:9] == 3'b101 |->
      pc_jump_en && pc_target == instruction_word[8:0])
      else $error("jump target wrong");
   call_tgt_a: assert property (instruction_word[11:8] == 4'h9 |->
      pc_call_en && pc_target == {1'b0, instruction_word[7:0]})
      else $error("call target wrong");
   pd_hold_a: assert property ((power_down_ctl && !master_reset) |=>
      power_down_ctl && sleep_out && !next_instruction_strobe)
      else $error("power-down released early");
   restart_pulse_a: assert property ($rose(power_down_ctl) |->
      instruction_word == 12'h003 && watchdog_restart ##1 !watchdog_restart [*3])
      else $error("restart not a single pulse");
   reset_nop_a: assert property (master_reset |=>
      instruction_word == 12'h000 && !power_down_ctl && next_instruction_strobe)
      else $error("master reset not a no-op");
endmodule : op_decoder_unit

// file: dv/prog_memory_model.sv
`timescale 1ns/1ps
module prog_memory_model (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // Decoder side
   input  wire logic        next_instruction_strobe,
   output logic [11:0]      fetch_word
);
   // ***********************************
   // Program store
   // ***********************************
   logic [11:0] mem [256];
   logic [7:0]  addr_q;

   // Address steps on every load, so the next word settles for a full cycle
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         addr_q <= 8'h00;
      else if (next_instruction_strobe)
         addr_q <= addr_q + 8'h01;
   end

   assign fetch_word = mem[addr_q];
endmodule : prog_memory_model

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   // ***********************************
   // Signals
   // ***********************************
   typedef struct packed {logic [11:0] w; logic zr; logic bt; logic [31:0] exp;} row_t;
   logic        ref_clk = 1'h0;
   logic        rstn = 1'h0;
   logic        watchdog_reset = 1'h0;
   logic        ext_reset_pin = 1'h0;
   logic [4:0]  index_low = 5'h15;
   logic        zero_result = 1'h0;
   logic        bit_test_result = 1'h1;
   logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [11:0] fetch_word, instruction_word;
   logic        pready, pslverr, next_instruction_strobe, accumulator_load_en, register_write_en;
   logic [3:0]  alu_function_code;
   logic [4:0]  register_address;
   logic [2:0]  bit_number;
   logic [7:0]  literal_value;
   logic [8:0]  pc_target;
   logic        pc_jump_en, pc_call_en, pc_return_en, port0_dir_load_en, port1_dir_load_en;
   logic        port2_dir_load_en, timer_option_load_en, watchdog_restart, power_down_ctl, sleep_out;
   int          n_fail = 0;
   int          num_checks = 0;
   row_t        rows[$];
   logic [3:0]  std_alu [16] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                                 4'h8, 4'h9, 4'hA, 4'h3, 4'hC, 4'hD, 4'hE, 4'hA};
   wire  [9:0]  en_v = {accumulator_load_en, register_write_en, pc_jump_en, pc_call_en, pc_return_en,
                        port0_dir_load_en, port1_dir_load_en, port2_dir_load_en, timer_option_load_en,
                        watchdog_restart};
   wire  [31:0] obs = {5'h00, instruction_word, alu_function_code, en_v, next_instruction_strobe};

   always #2 ref_clk = ~ref_clk;

   op_decoder_unit dut (
      .ref_clk(ref_clk), .rstn(rstn), .watchdog_reset(watchdog_reset), .ext_reset_pin(ext_reset_pin),
      .fetch_word(fetch_word), .index_low(index_low), .zero_result(zero_result),
      .bit_test_result(bit_test_result), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .instruction_word(instruction_word), .next_instruction_strobe(next_instruction_strobe),
      .alu_function_code(alu_function_code), .accumulator_load_en(accumulator_load_en),
      .register_write_en(register_write_en), .register_address(register_address),
      .bit_number(bit_number), .literal_value(literal_value), .pc_target(pc_target),
      .pc_jump_en(pc_jump_en), .pc_call_en(pc_call_en), .pc_return_en(pc_return_en),
      .port0_dir_load_en(port0_dir_load_en), .port1_dir_load_en(port1_dir_load_en),
      .port2_dir_load_en(port2_dir_load_en), .timer_option_load_en(timer_option_load_en),
      .watchdog_restart(watchdog_restart), .power_down_ctl(power_down_ctl), .sleep_out(sleep_out));

   prog_memory_model mem_u (.ref_clk(ref_clk), .rstn(rstn),
      .next_instruction_strobe(next_instruction_strobe), .fetch_word(fetch_word));

   // ***********************************
   // Tasks
   // ***********************************
   task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic add(input logic [11:0] w, input logic [11:0] iw, input logic [3:0] alu,
                      input logic [9:0] en, input logic st, input logic zr = 1'h0, input logic bt = 1'h1);
      rows.push_back('{w, zr, bt, {5'h00, iw, alu, en, st}});
   endtask : add

   // Request held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      @(posedge ref_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'h0;
      @(posedge ref_clk);
      penable <= 1'h1;
      // No cycle count assumed; only the watchdog ends a stuck wait
      do
      begin
         @(posedge ref_clk);
      end
      while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      #40000;
      n_fail++;
      tally_and_finish();
   end

   // ***********************************
   // Main sequence
   // ***********************************
   initial
   begin
      row_t        r;
      logic [31:0] rd;
      logic        er;
      int          n;
      logic [11:0] iw;
      add(12'h000, 12'h000, 4'h0, 10'h000, 1'h1);
      add(12'h002, 12'h002, 4'h0, 10'h002, 1'h1);
      add(12'h004, 12'h004, 4'h0, 10'h001, 1'h1);
      add(12'h005, 12'h005, 4'h0, 10'h010, 1'h1);
      add(12'h006, 12'h006, 4'h0, 10'h008, 1'h1);
      add(12'h007, 12'h007, 4'h0, 10'h004, 1'h1);
      add(12'h001, 12'h001, 4'h0, 10'h000, 1'h1);
      add(12'h01F, 12'h01F, 4'h0, 10'h000, 1'h1);
      add(12'h02A, 12'h02A, 4'h0, 10'h100, 1'h1);
      for (int k = 1; k < 16; k++)
         for (int d = 0; d < 2; d++)
            add({2'h0, k[3:0], d[0], 5'h03}, {2'h0, k[3:0], d[0], 5'h03}, std_alu[k],
                (d == 1) ? 10'h100 : 10'h200, 1'h1);
      add(12'h1E0, 12'h1E0, 4'h7, 10'h100, 1'h1);
      add(12'h1E2, 12'h1E2, 4'h7, 10'h100, 1'h0);
      add(12'h4A4, 12'h4A4, 4'hB, 10'h100, 1'h1);
      add(12'h5A4, 12'h5A4, 4'hF, 10'h100, 1'h1);
      add(12'h6A4, 12'h6A4, 4'h0, 10'h000, 1'h1, 1'h0, 1'h1);
      add(12'h7A4, 12'h7A4, 4'h0, 10'h000, 1'h1, 1'h0, 1'h0);
      add(12'h2E3, 12'h2E3, 4'h3, 10'h100, 1'h1, 1'h1);
      add(12'h5A4, 12'h000, 4'h0, 10'h000, 1'h1);
      add(12'h3E3, 12'h3E3, 4'hA, 10'h100, 1'h1, 1'h1);
      add(12'h5A4, 12'h000, 4'h0, 10'h000, 1'h1);
      add(12'h6A4, 12'h6A4, 4'h0, 10'h000, 1'h1, 1'h0, 1'h0);
      add(12'h4A4, 12'h000, 4'h0, 10'h000, 1'h1);
      add(12'h7A4, 12'h7A4, 4'h0, 10'h000, 1'h1, 1'h0, 1'h1);
      add(12'h4A4, 12'h000, 4'h0, 10'h000, 1'h1);
      add(12'hC5A, 12'hC5A, 4'h0, 10'h200, 1'h1);
      add(12'hD5A, 12'hD5A, 4'h4, 10'h200, 1'h1);
      add(12'hE5A, 12'hE5A, 4'h5, 10'h200, 1'h1);
      add(12'hF5A, 12'hF5A, 4'h6, 10'h200, 1'h1);
      add(12'h812, 12'h812, 4'h0, 10'h220, 1'h0);
      add(12'h9FF, 12'h9FF, 4'h0, 10'h040, 1'h0);
      add(12'hB23, 12'hB23, 4'h0, 10'h080, 1'h0);
      add(12'hA00, 12'hA00, 4'h0, 10'h080, 1'h0);
      // Tail of the store is all power-down, so each master reset sleeps again
      for (int i = 0; i < 256; i++)
         mem_u.mem[i] = (i < rows.size()) ? rows[i].w : 12'h003;
      repeat (4) @(posedge ref_clk);
      rstn <= 1'h1;
      foreach (rows[i])
      begin
         r = rows[i];
         n = 0;
         while (next_instruction_strobe !== 1'h1 && n < 8)
         begin
            @(posedge ref_clk);
            #1;
            n++;
         end
         @(posedge ref_clk);
         zero_result <= r.zr;
         bit_test_result <= r.bt;
         #1;
         iw = r.exp[26:15];
         cmp(obs, r.exp);
         if (iw[11] == 1'h0 && iw[11:5] != 7'h00)
            cmp(register_address, (iw[4:0] == 5'h00) ? index_low : iw[4:0]);
         if (iw[11:10] == 2'h1)
            cmp(bit_number, iw[7:5]);
         if (iw[11:10] == 2'h3 || iw[11:8] == 4'h8)
            cmp(literal_value, iw[7:0]);
         if (iw[11:9] == 3'h5)
            cmp(pc_target, iw[8:0]);
         if (iw[11:8] == 4'h9)
            cmp(pc_target, {1'h0, iw[7:0]});
         if (r.exp[0] == 1'h0)
         begin
            @(posedge ref_clk);
            #1;
            cmp(obs, r.exp | 32'h1);
         end
      end
      @(posedge ref_clk);
      #1;
      cmp({instruction_word, power_down_ctl, sleep_out, watchdog_restart, next_instruction_strobe},
          {12'h003, 4'hE});
      repeat (3) @(posedge ref_clk);
      #1;
      cmp({instruction_word, power_down_ctl, sleep_out, watchdog_restart, next_instruction_strobe},
          {12'h003, 4'hC});
      apb(1'h0, 12'h004, 32'h0, rd, er);
      cmp({er, rd}, {1'h0, 32'h0004_1003});
      apb(1'h1, 12'h004, 32'hFFFF_FFFF, rd, er);
      apb(1'h0, 12'h004, 32'h0, rd, er);
      cmp({er, rd}, {1'h0, 32'h0004_1003});
      apb(1'h1, 12'h008, 32'h0, rd, er);
      apb(1'h0, 12'h008, 32'h0, rd, er);
      cmp({er, rd}, {1'h0, 32'h0});
      apb(1'h0, 12'h000, 32'h0, rd, er);
      cmp({er, rd}, {1'h0, 32'h0});
      apb(1'h1, 12'h00C, 32'h1, rd, er);
      cmp(er, 1'h1);
      apb(1'h0, 12'h00C, 32'h0, rd, er);
      cmp({er, rd}, {1'h1, 32'h0});
      for (int s = 0; s < 3; s++)
      begin
         if (s == 0)
            apb(1'h1, 12'h000, 32'h1, rd, er);
         else
         begin
            @(posedge ref_clk);
            watchdog_reset <= (s == 1);
            ext_reset_pin <= (s == 2);
            repeat (3) @(posedge ref_clk);
            watchdog_reset <= 1'h0;
            ext_reset_pin <= 1'h0;
         end
         #1;
         n = 0;
         while (power_down_ctl !== 1'h0 && n < 20)
         begin
            @(posedge ref_clk);
            #1;
            n++;
         end
         cmp({instruction_word, next_instruction_strobe}, {12'h000, 1'h1});
         n = 0;
         while (power_down_ctl !== 1'h1 && n < 20)
         begin
            @(posedge ref_clk);
            #1;
            n++;
         end
         cmp({sleep_out, watchdog_restart, instruction_word}, {2'h3, 12'h003});
      end
      tally_and_finish();
   end
endmodule : tb_top
